// ===== ewc_regs.svh
// register map, fields, opcodes, resets
`ifndef EWC_REGS_SVH
`define EWC_REGS_SVH
`define EWC_OFF_COUNT 8'h00
`define EWC_OFF_LBA_LOW 8'h04
`define EWC_OFF_LBA_MID 8'h08
`define EWC_OFF_LBA_HIGH 8'h0C
`define EWC_OFF_CTRL 8'h10
`define EWC_OFF_CMD_STAT 8'h14
`define EWC_OFF_ERROR 8'h18
`define EWC_OFF_ALT_STAT 8'h1C
`define EWC_OPC_WRITE_EXT 8'h35
`define EWC_OPC_WRITE_FUA_EXT 8'h3D
`define EWC_CTRL_HIGH_BYTE_READBACK_SELECT 7
`define EWC_CTRL_WRITE_CACHE_ENABLE 0
`define EWC_CTRL_RESET 8'h00
`define EWC_ST_BUSY 7
`define EWC_ST_READY 6
`define EWC_ST_FAULT 5
`define EWC_ST_SEEK_COMPLETE_FLAG 4
`define EWC_ST_DATA_REQUEST 3
`define EWC_ST_CORRECTED_DATA_FLAG 2
`define EWC_ST_INDEX_PULSE_FLAG 1
`define EWC_ST_ERROR 0
`define EWC_ER_INTERFACE_CRC 7
`define EWC_ER_UNCORRECTABLE_DATA_FLAG 6
`define EWC_ER_SECTOR_NOT_FOUND_FLAG 4
`define EWC_ER_COMMAND_ABORTED_FLAG 2
`define EWC_ER_TIMEOUT_FLAG 1
`define EWC_ER_ADDRESS_MARK_MISSING_FLAG 0
`define EWC_WORDS_PER_SECTOR 256
`define EWC_MAX_LBA 48'hFFFF_FFFF_FFFF
`define EWC_RESP_OKAY 2'h0
`define EWC_RESP_SLVERR 2'h2
`endif

// ===== ewc_pkg.sv
// types shared by the write command block
package ewc_pkg;
    typedef enum logic [2:0] {
        EWC_IDLE,
        EWC_CHECK,
        EWC_XFER,
        EWC_COMMIT,
        EWC_FLUSH,
        EWC_END
    } ewc_state_t;
    typedef logic [47:0] ewc_lba_t;
endpackage

// ===== ewc_sector_if.sv
// sequencer to sector mover handshake
`timescale 1ns/10ps
interface ewc_sector_if;
    logic go;
    logic done;
    modport seq (output go, input done);
    modport mover (input go, output done);
endinterface

// ===== ewc_sector_mover.sv
// moves one sector of dma words to media
`timescale 1ns/10ps
`include "ewc_regs.svh"
module ewc_sector_mover import ewc_pkg::*; #(
    parameter int WORDS = `EWC_WORDS_PER_SECTOR
) (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    ewc_sector_if.mover sec_if,
    input wire logic dma_wr_in,
    input wire logic [15:0] dma_data_in,
    input wire logic media_ready_in,
    output logic dma_req_out,
    output logic media_valid_out,
    output logic media_last_out,
    output logic [15:0] media_data_out
);
    localparam int CW = $clog2(WORDS + 1);
    logic busy_q, req_q, mv_q, last_q, done_q;
    logic [CW-1:0] left_q, left_nx;
    logic [15:0] data_q;
    logic take, drain, start, mv_nx, busy_nx;

    // take only while request shown
    assign take = req_q & dma_wr_in;
    assign drain = mv_q & media_ready_in;
    assign start = sec_if.go & ~busy_q;
    assign left_nx = start ? CW'(WORDS) : left_q - CW'(take);
    assign mv_nx = take | (mv_q & ~media_ready_in);
    assign busy_nx = start | (busy_q & ~(drain & (left_q == '0)));

    // sector word counter
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            busy_q <= 1'b0;
            left_q <= '0;
        end else if (ce_in) begin
            busy_q <= busy_nx;
            left_q <= left_nx;
        end
    end

    // request drops while slot full: backpressure
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            req_q <= 1'b0;
        end else if (ce_in) begin
            req_q <= busy_nx & (left_nx != '0) & ~mv_nx;
        end
    end

    // one-word slot to media
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mv_q <= 1'b0;
            last_q <= 1'b0;
            data_q <= 16'h0000;
        end else if (ce_in) begin
            mv_q <= mv_nx;
            if (take) begin
                data_q <= dma_data_in;
                last_q <= (left_nx == '0);
            end
        end
    end

    // sector end after last word drains
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            done_q <= 1'b0;
        end else if (ce_in) begin
            done_q <= busy_q & drain & (left_q == '0);
        end
    end

    assign sec_if.done = done_q;
    assign dma_req_out = req_q;
    assign media_valid_out = mv_q;
    assign media_last_out = last_q;
    assign media_data_out = data_q;
endmodule

// ===== ewc_write_cmd.sv
// extended dma write command engine with axi4-lite task file
//
// The register offsets and the AXI4-Lite register port were decided locally.
`timescale 1ns/10ps
`include "ewc_regs.svh"
module ewc_write_cmd import ewc_pkg::*; #(
    parameter int WORDS_PER_SECTOR = `EWC_WORDS_PER_SECTOR,
    parameter logic [47:0] MAX_LBA = `EWC_MAX_LBA
) (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic ce_in,
    input wire logic [7:0] s_axi_awaddr_in,
    input wire logic s_axi_awvalid_in,
    output logic s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0] s_axi_wstrb_in,
    input wire logic s_axi_wvalid_in,
    output logic s_axi_wready_out,
    output logic [1:0] s_axi_bresp_out,
    output logic s_axi_bvalid_out,
    input wire logic s_axi_bready_in,
    input wire logic [7:0] s_axi_araddr_in,
    input wire logic s_axi_arvalid_in,
    output logic s_axi_arready_out,
    output logic [31:0] s_axi_rdata_out,
    output logic [1:0] s_axi_rresp_out,
    output logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    output logic dma_req_out,
    input wire logic dma_wr_in,
    input wire logic [15:0] dma_data_in,
    input wire logic dma_crc_err_in,
    output logic intrq_out,
    output logic media_valid_out,
    output logic media_last_out,
    output logic [15:0] media_data_out,
    output logic [47:0] media_lba_out,
    input wire logic media_ready_in,
    input wire logic media_ack_in,
    input wire logic media_fail_in,
    output logic media_flush_out,
    input wire logic media_flush_done_in
);
    generate
        if (WORDS_PER_SECTOR < 1 || WORDS_PER_SECTOR > 65535) begin : g_chk
            $error("words per sector out of range");
        end
    endgenerate

    ewc_sector_if sec_if ();
    ewc_state_t state_q;
    logic [7:0] tf_cur_q [4];
    logic [7:0] tf_prev_q [4];
    logic [7:0] ctrl_q, err_q;
    logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic [1:0] bresp_q, rresp_q;
    logic [31:0] rdata_q;
    logic fua_q, crc_q, go_q, flush_q, intrq_q, err_flag_q;
    logic [16:0] remain_q;
    ewc_lba_t lba_q;
    logic wr_fire, rd_fire, cmd_wr, start_ok, start_bad, busy;
    logic range_bad, stat_rd, load_fail, finish;
    logic [48:0] last_lba;
    logic [7:0] status_w;

    // task file byte index: count, low, mid, high
    function automatic logic tf_hit(input logic [7:0] a);
        return a <= `EWC_OFF_LBA_HIGH && a[1:0] == 2'h0;
    endfunction
    function automatic logic [1:0] tf_idx(input logic [7:0] a);
        return a[3:2];
    endfunction
    function automatic logic mapped(input logic [7:0] a);
        return a <= `EWC_OFF_ALT_STAT && a[1:0] == 2'h0;
    endfunction

    assign busy = (state_q != EWC_IDLE);
    assign wr_fire = awready_q & s_axi_awvalid_in;
    assign rd_fire = arready_q & s_axi_arvalid_in;
    assign cmd_wr = wr_fire & s_axi_wstrb_in[0] & ~busy
        & (s_axi_awaddr_in == `EWC_OFF_CMD_STAT);
    // only the two write opcodes start a command; any other opcode written while idle aborts
    assign start_ok = cmd_wr
        & ((s_axi_wdata_in[7:0] == `EWC_OPC_WRITE_EXT)
        | (s_axi_wdata_in[7:0] == `EWC_OPC_WRITE_FUA_EXT));
    assign start_bad = cmd_wr & ~start_ok;
    assign stat_rd = rd_fire & (s_axi_araddr_in == `EWC_OFF_CMD_STAT);
    assign last_lba = {1'b0, lba_q} + {32'h0, remain_q} - 49'h1;
    assign range_bad = last_lba > {1'b0, MAX_LBA};
    assign load_fail = (state_q == EWC_CHECK && range_bad)
        || (state_q == EWC_COMMIT && media_ack_in && media_fail_in);
    assign finish = (state_q == EWC_END) || start_bad;

    // write channel, address and data together
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= `EWC_RESP_OKAY;
        end else if (ce_in) begin
            awready_q <= s_axi_awvalid_in & s_axi_wvalid_in & ~awready_q
                & ~bvalid_q;
            wready_q <= s_axi_awvalid_in & s_axi_wvalid_in & ~awready_q
                & ~bvalid_q;
            if (wr_fire) begin
                bvalid_q <= 1'b1;
                bresp_q <= mapped(s_axi_awaddr_in) ? `EWC_RESP_OKAY
                    : `EWC_RESP_SLVERR;
            end else if (s_axi_bready_in) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // read channel with registered data
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rresp_q <= `EWC_RESP_OKAY;
            rdata_q <= 32'h0000_0000;
        end else if (ce_in) begin
            arready_q <= s_axi_arvalid_in & ~arready_q & ~rvalid_q;
            if (rd_fire) begin
                rvalid_q <= 1'b1;
                rresp_q <= mapped(s_axi_araddr_in) ? `EWC_RESP_OKAY
                    : `EWC_RESP_SLVERR;
                rdata_q <= {24'h000000, read_mux(s_axi_araddr_in)};
            end else if (s_axi_rready_in) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    // status is fixed apart from busy and error
    always_comb begin
        status_w = 8'h00;
        status_w[`EWC_ST_BUSY] = busy;
        status_w[`EWC_ST_READY] = 1'b1;
        status_w[`EWC_ST_SEEK_COMPLETE_FLAG] = 1'b1;
        status_w[`EWC_ST_ERROR] = err_flag_q;
    end

    // byte select picks readback half
    function automatic logic [7:0] read_mux(input logic [7:0] a);
        logic hi;
        hi = ctrl_q[`EWC_CTRL_HIGH_BYTE_READBACK_SELECT];
        if (tf_hit(a)) begin
            return hi ? tf_prev_q[tf_idx(a)] : tf_cur_q[tf_idx(a)];
        end
        case (a)
            `EWC_OFF_CTRL: return ctrl_q;
            `EWC_OFF_CMD_STAT: return status_w;
            `EWC_OFF_ALT_STAT: return status_w;
            `EWC_OFF_ERROR: return err_q;
            default: return 8'h00;
        endcase
    endfunction

    // task file: current shifts to previous; host writes ignored while busy, failing lba loaded on error
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            for (int i = 0; i < 4; i++) begin
                tf_cur_q[i] <= 8'h00;
                tf_prev_q[i] <= 8'h00;
            end
        end else if (ce_in) begin
            if (load_fail) begin
                tf_cur_q[1] <= lba_q[7:0];
                tf_cur_q[2] <= lba_q[15:8];
                tf_cur_q[3] <= lba_q[23:16];
                tf_prev_q[1] <= lba_q[31:24];
                tf_prev_q[2] <= lba_q[39:32];
                tf_prev_q[3] <= lba_q[47:40];
            end else if (wr_fire && !busy && s_axi_wstrb_in[0]
                    && tf_hit(s_axi_awaddr_in)) begin
                tf_prev_q[tf_idx(s_axi_awaddr_in)] <=
                    tf_cur_q[tf_idx(s_axi_awaddr_in)];
                tf_cur_q[tf_idx(s_axi_awaddr_in)] <= s_axi_wdata_in[7:0];
            end
        end
    end

    // control: readback select, write cache
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ctrl_q <= `EWC_CTRL_RESET;
        end else if (ce_in) begin
            if (wr_fire && s_axi_wstrb_in[0]
                    && s_axi_awaddr_in == `EWC_OFF_CTRL) begin
                ctrl_q <= s_axi_wdata_in[7:0];
            end
        end
    end

    // command sequencer, one sector at a time so a failure stops cleanly
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_q <= EWC_IDLE;
            go_q <= 1'b0;
            flush_q <= 1'b0;
        end else if (ce_in) begin
            go_q <= 1'b0;
            case (state_q)
                EWC_IDLE: begin
                    if (start_ok) begin
                        state_q <= EWC_CHECK;
                    end
                end
                EWC_CHECK: begin
                    if (range_bad) begin
                        state_q <= EWC_END;
                    end else begin
                        go_q <= 1'b1;
                        state_q <= EWC_XFER;
                    end
                end
                EWC_XFER: begin
                    if (sec_if.done) begin
                        state_q <= EWC_COMMIT;
                    end
                end
                EWC_COMMIT: begin
                    if (media_ack_in) begin
                        if (media_fail_in) begin
                            state_q <= EWC_END;
                        end else if (remain_q != 17'h1) begin
                            go_q <= 1'b1;
                            state_q <= EWC_XFER;
                        end else if (fua_q
                                || !ctrl_q[`EWC_CTRL_WRITE_CACHE_ENABLE]) begin
                            flush_q <= 1'b1;
                            state_q <= EWC_FLUSH;
                        end else begin
                            state_q <= EWC_END;
                        end
                    end
                end
                EWC_FLUSH: begin
                    if (media_flush_done_in) begin
                        flush_q <= 1'b0;
                        state_q <= EWC_END;
                    end
                end
                EWC_END: begin
                    state_q <= EWC_IDLE;
                end
                default: begin
                    state_q <= EWC_IDLE;
                    flush_q <= 1'b0;
                end
            endcase
        end
    end

    // start address, count and per-command mode
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            lba_q <= 48'h0000_0000_0000;
            remain_q <= 17'h00000;
            fua_q <= 1'b0;
        end else if (ce_in) begin
            if (start_ok) begin
                lba_q <= {tf_prev_q[3], tf_prev_q[2], tf_prev_q[1],
                    tf_cur_q[3], tf_cur_q[2], tf_cur_q[1]};
                remain_q <= {(tf_prev_q[0] == 8'h00 && tf_cur_q[0] == 8'h00),
                    tf_prev_q[0], tf_cur_q[0]};
                fua_q <= (s_axi_wdata_in[7:0] == `EWC_OPC_WRITE_FUA_EXT);
            end else if (state_q == EWC_COMMIT && media_ack_in
                    && !media_fail_in && remain_q != 17'h1) begin
                lba_q <= lba_q + 48'h1;
                remain_q <= remain_q - 17'h1;
            end
        end
    end

    // link crc errors, reported only at the end
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            crc_q <= 1'b0;
        end else if (ce_in) begin
            if (dma_crc_err_in && busy) begin
                crc_q <= 1'b1;
            end else if (start_ok) begin
                crc_q <= 1'b0;
            end
        end
    end

    // ending error register; uncorrectable, timeout, mark bits stay zero
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            err_q <= 8'h00;
            err_flag_q <= 1'b0;
        end else if (ce_in) begin
            if (start_ok) begin
                err_q <= 8'h00;
                err_flag_q <= 1'b0;
            end else if (load_fail || start_bad) begin
                err_q <= 8'h00; // no stale cause from an earlier command
                err_q[`EWC_ER_SECTOR_NOT_FOUND_FLAG] <=
                    (state_q == EWC_CHECK);
                err_q[`EWC_ER_COMMAND_ABORTED_FLAG] <=
                    (state_q != EWC_CHECK);
                err_flag_q <= 1'b1;
            end else if (state_q == EWC_END && crc_q) begin
                err_q[`EWC_ER_INTERFACE_CRC] <= 1'b1;
                err_flag_q <= 1'b1;
            end
        end
    end

    // one interrupt per command; a new completion beats a status read
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            intrq_q <= 1'b0;
        end else if (ce_in) begin
            if (finish) begin
                intrq_q <= 1'b1;
            end else if (stat_rd || start_ok) begin
                intrq_q <= 1'b0;
            end
        end
    end

    ewc_sector_mover #(
        .WORDS(WORDS_PER_SECTOR)
    ) u_mover (
        .clk_sys_in(clk_sys_in),
        .rst_n_in(rst_n_in),
        .ce_in(ce_in),
        .sec_if(sec_if.mover),
        .dma_wr_in(dma_wr_in),
        .dma_data_in(dma_data_in),
        .media_ready_in(media_ready_in),
        .dma_req_out(dma_req_out),
        .media_valid_out(media_valid_out),
        .media_last_out(media_last_out),
        .media_data_out(media_data_out)
    );

    assign sec_if.go = go_q;
    assign s_axi_awready_out = awready_q;
    assign s_axi_wready_out = wready_q;
    assign s_axi_bvalid_out = bvalid_q;
    assign s_axi_bresp_out = bresp_q;
    assign s_axi_arready_out = arready_q;
    assign s_axi_rvalid_out = rvalid_q;
    assign s_axi_rresp_out = rresp_q;
    assign s_axi_rdata_out = rdata_q;
    assign intrq_out = intrq_q;
    assign media_lba_out = lba_q;
    assign media_flush_out = flush_q;
endmodule

// ===== ewc_write_cmd_asserts.sv
// port-level checks for the write command block
`timescale 1ns/10ps
module ewc_write_cmd_asserts (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic dma_req_out,
    input wire logic dma_wr_in,
    input wire logic [15:0] dma_data_in,
    input wire logic media_valid_out,
    input wire logic media_ready_in,
    input wire logic [15:0] media_data_out,
    input wire logic media_ack_in,
    input wire logic media_fail_in,
    input wire logic media_flush_out,
    input wire logic media_flush_done_in,
    input wire logic intrq_out,
    input wire logic s_axi_awready_out,
    input wire logic s_axi_bvalid_out,
    input wire logic s_axi_rvalid_out,
    input wire logic s_axi_rready_in,
    input wire logic [31:0] s_axi_rdata_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);
    // one word per slot
    property p_req_drop;
        dma_req_out && dma_wr_in |=> !dma_req_out;
    endproperty
    a_req_drop: assert property (p_req_drop) else $error("req held");
    property p_word_fwd;
        dma_req_out && dma_wr_in |=>
            media_valid_out && media_data_out == $past(dma_data_in);
    endproperty
    a_word_fwd: assert property (p_word_fwd) else $error("word lost");
    property p_media_cause;
        $rose(media_valid_out) |-> $past(dma_req_out && dma_wr_in);
    endproperty
    a_media_cause: assert property (p_media_cause) else $error("stray");
    property p_media_hold;
        media_valid_out && !media_ready_in |=>
            media_valid_out && $stable(media_data_out);
    endproperty
    a_media_hold: assert property (p_media_hold) else $error("stalled");
    property p_flush_hold;
        media_flush_out && !media_flush_done_in |=> media_flush_out;
    endproperty
    a_flush_hold: assert property (p_flush_hold) else $error("flush");
    // irq only after wind-down
    property p_irq_quiet;
        $rose(intrq_out) |-> !dma_req_out && !media_valid_out
            && !media_flush_out;
    endproperty
    a_irq_quiet: assert property (p_irq_quiet) else $error("irq busy");
    property p_fail_stop;
        media_ack_in && media_fail_in |=> !dma_req_out [*4];
    endproperty
    a_fail_stop: assert property (p_fail_stop) else $error("fail req");
    property p_bresp;
        s_axi_awready_out |=> s_axi_bvalid_out;
    endproperty
    a_bresp: assert property (p_bresp) else $error("bresp late");
    property p_rhold;
        s_axi_rvalid_out && !s_axi_rready_in |=>
            s_axi_rvalid_out && $stable(s_axi_rdata_out);
    endproperty
    a_rhold: assert property (p_rhold) else $error("rdata moved");
    c_irq: cover property ($rose(intrq_out));
    c_flush: cover property ($rose(media_flush_out));
    c_fail: cover property (media_ack_in && media_fail_in);
endmodule
bind ewc_write_cmd ewc_write_cmd_asserts u_chk (.*);

// ===== ewc_host_dma.sv
// host dma channel model
`timescale 1ns/10ps
module ewc_host_dma (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic dma_req_in,
    input wire logic slow_in,
    output logic dma_wr_out,
    output logic [15:0] dma_data_out
);
    logic [15:0] n_q;
    logic [3:0] s_q;
    // strobe held until taken; released data inverted
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            n_q <= 16'h0000;
            s_q <= 4'h9;
            dma_wr_out <= 1'b0;
            dma_data_out <= 16'h0000;
        end else begin
            s_q <= {s_q[2:0], s_q[3] ^ s_q[2]};
            if (dma_wr_out && dma_req_in) begin
                dma_wr_out <= 1'b0;
                dma_data_out <= ~dma_data_out;
                n_q <= n_q + 16'h0001;
            end else if (!dma_wr_out && dma_req_in && (!slow_in || s_q[0]))
            begin
                dma_wr_out <= 1'b1;
                dma_data_out <= n_q * 16'h1D3B ^ 16'hC6A5;
            end
        end
    end
endmodule

// ===== testbench.sv
// bench for the write command block
`timescale 1ns/10ps
`include "ewc_regs.svh"
module testbench;
    localparam int W = 4;
    localparam logic [47:0] MAXL = 48'h0000_0001_0000;
    logic clk_sys_in, rst_n_in, ce_in, s_axi_awvalid_in, s_axi_wvalid_in;
    logic s_axi_bready_in, s_axi_arvalid_in, s_axi_rready_in, dma_wr_in;
    logic dma_crc_err_in, media_ready_in, media_ack_in, media_fail_in;
    logic media_flush_done_in, s_axi_awready_out, s_axi_wready_out;
    logic s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out, dma_req_out;
    logic intrq_out, media_valid_out, media_last_out, media_flush_out, slow;
    logic [7:0] s_axi_awaddr_in, s_axi_araddr_in;
    logic [31:0] s_axi_wdata_in, s_axi_rdata_out;
    logic [3:0] s_axi_wstrb_in;
    logic [1:0] s_axi_bresp_out, s_axi_rresp_out, r;
    logic [15:0] dma_data_in, media_data_out;
    logic [47:0] media_lba_out, lba_q;
    logic [31:0] rnd = 32'h8549;
    logic irq_l = 1'b0;
    int miscompares, samples_checked, cyc, wn, sec, fsec, irqs, flushes;
    int ack_t, fl_t;
    ewc_write_cmd #(.WORDS_PER_SECTOR(W), .MAX_LBA(MAXL)) DUT (.*);
    ewc_host_dma HOST (.clk_sys_in, .rst_n_in, .dma_req_in(dma_req_out),
        .slow_in(slow), .dma_wr_out(dma_wr_in), .dma_data_out(dma_data_in));
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function automatic logic [15:0] exp_word(input int n);
        return n * 16'h1D3B ^ 16'hC6A5;
    endfunction
    task automatic cmp(input logic [47:0] got, exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("FAIL %0t got %0h exp %0h", $time, got, exp);
        end
    endtask
    task automatic final_report;
        if (miscompares == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [7:0] d,
            output logic [1:0] re);
        @(posedge clk_sys_in);
        s_axi_awaddr_in <= a;
        s_axi_wdata_in <= {24'h0, d};
        s_axi_awvalid_in <= 1'b1;
        s_axi_wvalid_in <= 1'b1;
        s_axi_bready_in <= 1'b1;
        do @(posedge clk_sys_in); while (s_axi_awready_out !== 1'b1);
        s_axi_awvalid_in <= 1'b0;
        s_axi_wvalid_in <= 1'b0;
        while (s_axi_bvalid_out !== 1'b1) @(posedge clk_sys_in);
        re = s_axi_bresp_out;
        s_axi_bready_in <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e,
            input logic [1:0] re = 2'h0);
        @(posedge clk_sys_in);
        s_axi_araddr_in <= a;
        s_axi_arvalid_in <= 1'b1;
        s_axi_rready_in <= 1'b1;
        do @(posedge clk_sys_in); while (s_axi_arready_out !== 1'b1);
        s_axi_arvalid_in <= 1'b0;
        while (s_axi_rvalid_out !== 1'b1) @(posedge clk_sys_in);
        cmp(s_axi_rdata_out, {24'h0, e});
        cmp(s_axi_rresp_out, re);
        s_axi_rready_in <= 1'b0;
    endtask
    // previous, then current
    task automatic ld(input logic [7:0] a, input logic [15:0] v);
        axi_wr(a, v[15:8], r);
        axi_wr(a, v[7:0], r);
    endtask
    // m[0] cache on, m[1] crc fault
    task automatic run(input logic [7:0] op, input logic [15:0] cnt,
            input logic [47:0] lba, input int fail, input logic [1:0] m);
        int ce, ns, f0;
        logic bad, nf, fe;
        logic [7:0] er;
        logic [47:0] ea;
        bad = op != `EWC_OPC_WRITE_EXT && op != `EWC_OPC_WRITE_FUA_EXT;
        ce = cnt == 16'h0000 ? 65536 : int'(cnt);
        nf = !bad && lba + ce - 1 > MAXL;
        ns = bad || nf ? 0 : fail >= 0 ? fail + 1 : ce;
        fe = !bad && !nf && fail < 0 && (op == 8'h3D || !m[0]);
        er = {m[1], 2'h0, nf, 1'h0, bad || fail >= 0, 2'h0};
        sec = 0;
        fsec = fail;
        lba_q = lba;
        f0 = flushes;
        ld(`EWC_OFF_COUNT, cnt);
        ld(`EWC_OFF_LBA_LOW, {lba[31:24], lba[7:0]});
        ld(`EWC_OFF_LBA_MID, {lba[39:32], lba[15:8]});
        ld(`EWC_OFF_LBA_HIGH, {lba[47:40], lba[23:16]});
        axi_wr(`EWC_OFF_CTRL, {7'h0, m[0]}, r);
        irqs = 0;
        axi_wr(`EWC_OFF_CMD_STAT, op, r);
        if (m[1]) begin
            repeat (3) @(posedge clk_sys_in);
            dma_crc_err_in <= 1'b1;
            @(posedge clk_sys_in);
            dma_crc_err_in <= 1'b0;
        end
        while (intrq_out !== 1'b1) @(posedge clk_sys_in);
        repeat (4) @(posedge clk_sys_in);
        cmp(irqs, 1);
        cmp(sec, ns);
        cmp(flushes - f0, fe);
        rd_chk(`EWC_OFF_ERROR, er);
        rd_chk(`EWC_OFF_CMD_STAT, {7'h28, er != 8'h00});
        cmp(intrq_out, 1'b0);
        if (nf || fail >= 0) begin
            ea = nf ? lba : lba + fail;
            for (int h = 0; h < 2; h++) begin
                axi_wr(`EWC_OFF_CTRL, {h[0], 7'h0}, r);
                for (int k = 0; k < 3; k++)
                    rd_chk(8'(4 + 4 * k), ea[24 * h + 8 * k +: 8]);
            end
        end
    endtask
    initial begin
        clk_sys_in = 1'b0;
        forever #5 clk_sys_in = ~clk_sys_in;
    end
    // hang guard
    always @(posedge clk_sys_in) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            miscompares++;
            final_report();
        end
    end
    // media side model
    always @(posedge clk_sys_in) begin
        rnd <= lfsr(rnd);
        media_ready_in <= rnd[3] | rnd[7];
        media_ack_in <= 1'b0;
        media_fail_in <= 1'b0;
        media_flush_done_in <= 1'b0;
        irq_l <= intrq_out;
        if (intrq_out === 1'b1 && irq_l !== 1'b1) irqs++;
        if (media_valid_out === 1'b1 && media_ready_in === 1'b1) begin
            cmp(media_data_out, exp_word(wn));
            cmp(media_last_out, wn % W == W - 1);
            cmp(media_lba_out, lba_q + sec);
            wn++;
            if (wn % W == 0) ack_t = 3;
        end
        if (ack_t == 1) begin
            media_ack_in <= 1'b1;
            media_fail_in <= sec == fsec;
            sec++;
        end
        if (ack_t > 0) ack_t--;
        if (media_flush_out !== 1'b1) fl_t = 0;
        else if (fl_t == 0) fl_t = 4;
        if (fl_t == 2) begin
            media_flush_done_in <= 1'b1;
            flushes++;
        end
        if (fl_t > 1) fl_t--;
    end
    initial begin
        {rst_n_in, s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} = 0;
        {s_axi_arvalid_in, s_axi_rready_in, dma_crc_err_in, slow} = 0;
        {media_ready_in, media_ack_in, media_fail_in, media_flush_done_in} = 0;
        {s_axi_awaddr_in, s_axi_araddr_in, s_axi_wdata_in} = 0;
        s_axi_wstrb_in = 4'h1;
        ce_in = 1'b1;
        repeat (20) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        rd_chk(8'h20, 8'h00, `EWC_RESP_SLVERR);
        axi_wr(8'h02, 8'h35, r);
        cmp(r, `EWC_RESP_SLVERR);
        run(8'h35, 16'(rnd[1:0]) + 16'h1, {33'h0, rnd[14:0]}, -1, 2'h1);
        run(8'h3D, 16'h0002, {33'h0, rnd[30:16]}, -1, 2'h1);
        run(8'h35, 16'h0002, 48'h0000_0000_1200, -1, 2'h0);
        run(8'h35, 16'h0100, 48'h0000_0000_2000, -1, 2'h1);
        slow = 1'b1;
        run(8'h35, 16'h0004, 48'h0000_0000_0040, 1, 2'h1);
        run(8'h3D, 16'h0003, 48'h0000_0000_0080, 2, 2'h1);
        run(8'h35, 16'h0002, 48'h0000_0000_00C0, -1, 2'h3);
        slow = 1'b0;
        run(8'h35, 16'h0001, 48'hA1B2_C3D4_E5F6, -1, 2'h1);
        run(8'h35, 16'h0000, 48'h0000_0000_0002, -1, 2'h1);
        run(8'h35, 16'h0001, MAXL, -1, 2'h1);
        run(8'h35, 16'h0002, MAXL, -1, 2'h1);
        run(8'h30, 16'h0001, 48'h0000_0000_0010, -1, 2'h1);
        final_report();
    end
endmodule
